// ==== shared/cvt_regs.svh ====
// register locations, field positions, reset values and timing counts of the video timing unit
`ifndef CVT_REGS_SVH
`define CVT_REGS_SVH

// ----------------------------------------
// register locations
// ----------------------------------------
`define CVT_REG_HTOTAL 4'h0
`define CVT_REG_SYNC_CONFIG 4'h1
`define CVT_REG_ROW_FORMAT 4'h2
`define CVT_REG_SKEW_ROWS 4'h3
`define CVT_REG_FRAME_LINES 4'h4
`define CVT_REG_VDATA_START 4'h5
`define CVT_REG_SCROLL 4'h6
`define CVT_REG_CURSOR_COL 4'h7
`define CVT_REG_CURSOR_ROW 4'h8
`define CVT_REG_RESTART 4'hA

// ----------------------------------------
// field positions
// ----------------------------------------
`define CVT_INTERLACE_BIT 7
`define CVT_HS_WIDTH_MSB 6
`define CVT_HS_WIDTH_LSB 3
`define CVT_FPORCH_MSB 2
`define CVT_FPORCH_LSB 0
`define CVT_SCANS_MSB 6
`define CVT_SCANS_LSB 3
`define CVT_CPR_MSB 2
`define CVT_CPR_LSB 0
`define CVT_SKEW_HI_BIT 7
`define CVT_SKEW_LO_BIT 6
`define CVT_ROW_MSB 5
`define CVT_ROW_LSB 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define CVT_RST_HTOTAL 8'h7E
`define CVT_RST_SYNC_CONFIG 8'h4A
`define CVT_RST_ROW_FORMAT 8'h5D
`define CVT_RST_SKEW_ROWS 8'h17
`define CVT_RST_FRAME_LINES 8'h06
`define CVT_RST_VDATA_START 8'h14
`define CVT_RST_SCROLL 8'h17
`define CVT_RST_CURSOR 8'h00

// ----------------------------------------
// timing counts
// ----------------------------------------
`define CVT_VSYNC_LINES 3
`define CVT_NONINT_BASE 10'd256
`define CVT_INT_FIELD_BASE 10'd256

`endif

// ==== shared/cvt_pkg.sv ====
// types shared by the video timing unit
package cvt_pkg;

  typedef logic [7:0] cvt_byte_t;

  // synchronised host bus sample
  typedef struct packed {
    logic ce;
    logic rd;
    logic stb;
    logic [3:0] sel;
    cvt_byte_t data;
  } cvt_bus_s;

  // sync and blanking group that shares one skew
  typedef struct packed {
    logic hs;
    logic vs;
    logic cs;
    logic bl;
  } cvt_vid_s;

endpackage

// ==== rtl/cvt_video_timing.sv ====
// programmable character raster timing generator with host register port
// Function
// - sync config bit 7 high selects interlaced scan, low non-interlaced
// - hsync lasts sync config bits 6..3 character times
// - front porch from bits 2..0 between active video end and hsync
// - row format bits 6..3 are scans per row minus one; bit 7 ignored
// - row format bits 2..0 pick 20,32,40,64,72,80,96,132 characters per row
// - skew bits delay sync/blank and cursor by 0/0,1/0,2/1,2/2 character times
// - displayed data rows equal row count bits 5..0 plus one
// - frame lines: interlaced twice value plus 513, else value plus 256
// - first data row starts vertical data start lines after vsync start
// - scroll row shows at bottom, next row at top, numbering wraps
// - cursor at column matching cursor column register
// - cursor only on data row matching cursor row bits 5..0
// - separate hsync and vsync plus composite sync with serrations
// - one character clock per cell advances all timing counts
// - 8-bit data bus, 4-bit select and chip enable decode 16 locations
// - data strobe reads or writes, and triggers control functions
// - 4-bit raster line count gives scan within character row
// - blanking active in horizontal and vertical retrace
// - 8-bit column and 6-bit row counts; column runs through blanking
// - horizontal count register holds line length minus one
`include "cvt_regs.svh"

module cvt_video_timing
  import cvt_pkg::*;
#(
  parameter int VSYNC_LINES = `CVT_VSYNC_LINES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // character clock from dot counter
  input wire logic char_clock_in,
  // host port
  input wire logic chipEnable_n,
  input wire logic hostRead,
  input wire logic host_strobe,
  input wire logic [3:0] reg_select_lines,
  input wire logic [7:0] host_data_bus_in,
  output logic [7:0] host_data_bus_out,
  output logic host_data_bus_oe,
  // frame buffer and character generator addressing
  output logic [7:0] column_count_out,
  output logic [5:0] row_count_out,
  output logic [3:0] raster_line_count,
  // monitor timing
  output logic hsyncOut,
  output logic vsyncOut,
  output logic csyncOut,
  output logic blankOut,
  output logic cursorOut
);

  // elaboration refuses a vsync that the line counter cannot place
  if (VSYNC_LINES < 1 || VSYNC_LINES > 255) begin : gBadVsync
    $error("VSYNC_LINES out of range");
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] ccSync;
  cvt_bus_s busMeta;
  cvt_bus_s busSync;
  logic stbLast;
  logic charEn;
  logic writeEn;
  cvt_bus_s busIn;

  assign busIn = '{ce: ~chipEnable_n, rd: hostRead, stb: host_strobe, sel: reg_select_lines,
                   data: host_data_bus_in};

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ccSync <= 3'h0;
    end else begin
      ccSync <= {ccSync[1:0], char_clock_in};
    end
  end

  // one cell per rising edge of the character clock
  assign charEn = ccSync[1] & ~ccSync[2];

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      busMeta <= '0;
      busSync <= '0;
      stbLast <= 1'b0;
    end else begin
      busMeta <= busIn;
      busSync <= busMeta;
      stbLast <= busSync.stb;
    end
  end

  // bus lines settle before the strobe, so two stages suffice for them
  assign writeEn = busSync.stb & ~stbLast & busSync.ce & ~busSync.rd;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  cvt_byte_t hTotal, syncCfg, rowFmt, skewRows, frameLines, vdStart, scrollRow, curCol, curRow;
  logic restartReq;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hTotal <= `CVT_RST_HTOTAL;
      syncCfg <= `CVT_RST_SYNC_CONFIG;
      rowFmt <= `CVT_RST_ROW_FORMAT;
      skewRows <= `CVT_RST_SKEW_ROWS;
      frameLines <= `CVT_RST_FRAME_LINES;
      vdStart <= `CVT_RST_VDATA_START;
      scrollRow <= `CVT_RST_SCROLL;
      curCol <= `CVT_RST_CURSOR;
      curRow <= `CVT_RST_CURSOR;
    end else if (writeEn) begin
      case (busSync.sel)
        `CVT_REG_HTOTAL: hTotal <= busSync.data;
        `CVT_REG_SYNC_CONFIG: syncCfg <= busSync.data;
        `CVT_REG_ROW_FORMAT: rowFmt <= busSync.data;
        `CVT_REG_SKEW_ROWS: skewRows <= busSync.data;
        `CVT_REG_FRAME_LINES: frameLines <= busSync.data;
        `CVT_REG_VDATA_START: vdStart <= busSync.data;
        `CVT_REG_SCROLL: scrollRow <= busSync.data;
        `CVT_REG_CURSOR_COL: curCol <= busSync.data;
        `CVT_REG_CURSOR_ROW: curRow <= busSync.data;
        default: ;
      endcase
    end
  end

  // strobe on the restart location resynchronises the raster
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      restartReq <= 1'b0;
    end else begin
      restartReq <= writeEn && busSync.sel == `CVT_REG_RESTART;
    end
  end

  // read side; write-only locations answer zero
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      host_data_bus_out <= 8'h00;
      host_data_bus_oe <= 1'b0;
    end else begin
      host_data_bus_oe <= busSync.ce & busSync.rd & busSync.stb;
      case (busSync.sel)
        `CVT_REG_CURSOR_COL: host_data_bus_out <= curCol;
        `CVT_REG_CURSOR_ROW: host_data_bus_out <= curRow;
        default: host_data_bus_out <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // decoded settings
  // ----------------------------------------
  function automatic logic [8:0] charsPerRow(input logic [2:0] code);
    case (code)
      3'h0: charsPerRow = 9'd20;
      3'h1: charsPerRow = 9'd32;
      3'h2: charsPerRow = 9'd40;
      3'h3: charsPerRow = 9'd64;
      3'h4: charsPerRow = 9'd72;
      3'h5: charsPerRow = 9'd80;
      3'h6: charsPerRow = 9'd96;
      default: charsPerRow = 9'd132;
    endcase
  endfunction

  // skew taps: index 0 sync/blank, index 1 cursor
  function automatic logic [1:0] skewTap(input logic [1:0] bits, input logic cursor);
    case (bits)
      2'b00: skewTap = 2'd0;
      2'b10: skewTap = cursor ? 2'd0 : 2'd1;
      2'b01: skewTap = cursor ? 2'd1 : 2'd2;
      default: skewTap = 2'd2;
    endcase
  endfunction

  logic interlace;
  logic [3:0] hsWidth, scansMax;
  logic [2:0] frontPorch;
  logic [8:0] cpr, hsStart, hsEnd;
  logic [5:0] rowsMax, scrollLast, cursorRow;
  logic [1:0] skewBits;

  assign interlace = syncCfg[`CVT_INTERLACE_BIT];
  assign hsWidth = syncCfg[`CVT_HS_WIDTH_MSB:`CVT_HS_WIDTH_LSB];
  assign frontPorch = syncCfg[`CVT_FPORCH_MSB:`CVT_FPORCH_LSB];
  assign scansMax = rowFmt[`CVT_SCANS_MSB:`CVT_SCANS_LSB];
  assign cpr = charsPerRow(rowFmt[`CVT_CPR_MSB:`CVT_CPR_LSB]);
  assign skewBits = {skewRows[`CVT_SKEW_HI_BIT], skewRows[`CVT_SKEW_LO_BIT]};
  assign rowsMax = skewRows[`CVT_ROW_MSB:`CVT_ROW_LSB];
  assign scrollLast = scrollRow[`CVT_ROW_MSB:`CVT_ROW_LSB];
  assign cursorRow = curRow[`CVT_ROW_MSB:`CVT_ROW_LSB];
  assign hsStart = cpr + 9'(frontPorch);
  assign hsEnd = hsStart + 9'(hsWidth);

  // ----------------------------------------
  // horizontal and vertical counters
  // ----------------------------------------
  logic [7:0] hCount;
  logic [9:0] vLine, lastLine, nextLine;
  logic oddField, lineEnd, frameEnd;

  assign lineEnd = hCount == hTotal;
  // interlaced fields alternate v+256 and v+257 lines, summing to 2v+513
  assign lastLine = 10'(frameLines) + `CVT_NONINT_BASE - 10'd1 + 10'(interlace & oddField);
  assign frameEnd = lineEnd && vLine == lastLine;
  assign nextLine = frameEnd ? 10'd0 : vLine + 10'd1;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hCount <= 8'h00;
    end else if (restartReq) begin
      hCount <= 8'h00;
    end else if (charEn) begin
      hCount <= lineEnd ? 8'h00 : hCount + 8'h01;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      vLine <= 10'd0;
      oddField <= 1'b0;
    end else if (restartReq) begin
      vLine <= 10'd0;
      oddField <= 1'b0;
    end else if (charEn && lineEnd) begin
      vLine <= nextLine;
      if (frameEnd) begin
        oddField <= interlace & ~oddField;
      end
    end
  end

  // ----------------------------------------
  // data rows, scans and scroll
  // ----------------------------------------
  logic active;
  logic [3:0] scan;
  logic [5:0] rowIdx, dataRow, topRow;

  assign topRow = scrollLast == rowsMax ? 6'h00 : scrollLast + 6'h01;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      active <= 1'b0;
      scan <= 4'h0;
      rowIdx <= 6'h00;
      dataRow <= 6'h00;
    end else if (restartReq) begin
      active <= 1'b0;
      scan <= 4'h0;
    end else if (charEn && lineEnd) begin
      if (nextLine == 10'(vdStart)) begin
        active <= 1'b1;
        scan <= 4'h0;
        rowIdx <= 6'h00;
        dataRow <= topRow;
      end else if (frameEnd) begin
        active <= 1'b0;
      end else if (active) begin
        if (scan == scansMax) begin
          scan <= 4'h0;
          if (rowIdx == rowsMax) begin
            active <= 1'b0;
          end else begin
            rowIdx <= rowIdx + 6'h01;
            dataRow <= dataRow == rowsMax ? 6'h00 : dataRow + 6'h01;
          end
        end else begin
          scan <= scan + 4'h1;
        end
      end
    end
  end

  // ----------------------------------------
  // raw timing
  // ----------------------------------------
  logic hBlank, hsRaw, vsRaw, blankRaw, cursorRaw;
  logic [7:0] halfLine;
  cvt_vid_s vidRaw;

  assign halfLine = hTotal >> 1;
  assign hBlank = 9'(hCount) >= cpr;
  assign hsRaw = 9'(hCount) >= hsStart && 9'(hCount) < hsEnd;
  // odd field vsync is offset half a line to interlace
  assign vsRaw = (interlace && oddField) ?
                 ((vLine == 10'd0 && hCount >= halfLine) || (vLine > 10'd0 && vLine < 10'(VSYNC_LINES)) ||
                  (vLine == 10'(VSYNC_LINES) && hCount < halfLine)) :
                 vLine < 10'(VSYNC_LINES);
  assign blankRaw = hBlank | ~active;
  assign cursorRaw = active && !hBlank && hCount == curCol && dataRow == cursorRow;
  // serrations: hsync inverted while vsync is high
  assign vidRaw = '{hs: hsRaw, vs: vsRaw, cs: vsRaw ? ~hsRaw : hsRaw, bl: blankRaw};

  // ----------------------------------------
  // skew delay lines
  // ----------------------------------------
  cvt_vid_s vidPipe [1:2];
  logic curPipe [1:2];
  cvt_vid_s vidTap [0:2];
  logic curTap [0:2];
  logic [1:0] vidSel, curSel;

  assign vidTap[0] = vidRaw;
  assign curTap[0] = cursorRaw;
  assign vidSel = skewTap(skewBits, 1'b0);
  assign curSel = skewTap(skewBits, 1'b1);

  genvar g;
  generate
    for (g = 1; g <= 2; g++) begin : gSkew
      assign vidTap[g] = vidPipe[g];
      assign curTap[g] = curPipe[g];
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          vidPipe[g] <= '0;
          curPipe[g] <= 1'b0;
        end else if (charEn) begin
          vidPipe[g] <= vidTap[g-1];
          curPipe[g] <= curTap[g-1];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // output registers
  // ----------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hsyncOut <= 1'b0;
      vsyncOut <= 1'b0;
      csyncOut <= 1'b0;
      blankOut <= 1'b1;
      cursorOut <= 1'b0;
    end else begin
      hsyncOut <= vidTap[vidSel].hs;
      vsyncOut <= vidTap[vidSel].vs;
      csyncOut <= vidTap[vidSel].cs;
      blankOut <= vidTap[vidSel].bl;
      cursorOut <= curTap[curSel];
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      column_count_out <= 8'h00;
      row_count_out <= 6'h00;
      raster_line_count <= 4'h0;
    end else begin
      column_count_out <= hCount;
      row_count_out <= dataRow;
      raster_line_count <= scan;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  logic [4:0] hsLen;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hsLen <= 5'h00;
    end else if (!hsRaw) begin
      hsLen <= 5'h00;
    end else if (charEn) begin
      hsLen <= hsLen + 5'h01;
    end
  end

  AST_NO_ODD_FIELD: assert property ($rose(oddField) |-> $past(interlace))
    else $error("odd field entered while non-interlaced");
  AST_HSYNC_LEN: assert property ($fell(hsRaw) && !$past(restartReq) && hsEnd <= 9'(hTotal) + 9'd1
                                  && $stable(syncCfg) |-> hsLen == 5'(hsWidth))
    else $error("hsync width differs from setting");
  AST_HSYNC_START: assert property (hsWidth != 4'h0 && 9'(hCount) == hsStart |-> hsRaw && hBlank)
    else $error("hsync not started after front porch");
  AST_SCAN_WRAP: assert property (charEn && lineEnd && active && !restartReq && !frameEnd && scan == scansMax
                                  && nextLine != 10'(vdStart) |=> scan == 4'h0)
    else $error("scan count did not wrap at row end");
  AST_CPR_80: assert property (rowFmt[2:0] == 3'h5 |-> cpr == 9'd80)
    else $error("code 101 does not give 80 characters");
  AST_SKEW_ZERO: assert property (skewBits == 2'b00 |=> blankOut == $past(blankRaw))
    else $error("unskewed blank not passed straight through");
  AST_FRAME_WRAP: assert property (charEn && frameEnd && !restartReq |=> vLine == 10'd0)
    else $error("frame did not end at programmed line count");
  AST_VDS: assert property (charEn && lineEnd && !restartReq && nextLine == 10'(vdStart)
                            |=> active && rowIdx == 6'h00 && dataRow == $past(topRow))
    else $error("first data row not started at vertical data start");
  AST_CURSOR: assert property (cursorRaw |-> hCount == curCol && dataRow == cursorRow && !blankRaw)
    else $error("cursor outside its position");
  AST_CSYNC: assert property (!vsyncOut |-> csyncOut == hsyncOut)
    else $error("composite sync differs from hsync outside vsync");
  AST_READ_BACK: assert property (busSync.ce && busSync.rd && busSync.stb && busSync.sel == `CVT_REG_CURSOR_COL
                                  && $stable(curCol) |=> host_data_bus_oe && host_data_bus_out == curCol)
    else $error("cursor column not returned on read");

endmodule

// ==== tb/cvt_host_model.sv ====
// host processor and dot counter model that drives the video timing unit
module cvt_host_model
  import cvt_pkg::*;
(
  // clock
  input wire logic mclk,
  // host port
  output logic chipEnable_n,
  output logic hostRead,
  output logic host_strobe,
  output logic [3:0] reg_select_lines,
  output cvt_byte_t hostData,
  input wire logic host_data_bus_oe,
  input wire logic [7:0] host_data_bus_out,
  // dot counter carry
  output logic char_clock_in
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    chipEnable_n = 1'b1;
    hostRead = 1'b0;
    host_strobe = 1'b0;
    reg_select_lines = 4'h0;
    hostData = 8'h00;
    char_clock_in = 1'b0;
  end

  // ----
  // bus cycle
  // ----
  // strobe and select held past the two-stage synchroniser before release
  task automatic access(input logic [3:0] sel, input cvt_byte_t data, input logic rd, input logic ce,
                        output cvt_byte_t got);
    int n;
    n = 0;
    @(posedge mclk);
    reg_select_lines <= sel;
    hostData <= data;
    hostRead <= rd;
    chipEnable_n <= ~ce;
    host_strobe <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    while (rd && host_data_bus_oe !== 1'b1 && n < 8) begin
      @(posedge mclk);
      #1;
      n++;
    end
    got = host_data_bus_out;
    @(posedge mclk);
    host_strobe <= 1'b0;
    // released bus shows the inverse, not a stale copy
    hostData <= ~data;
    repeat (2) @(posedge mclk);
    chipEnable_n <= 1'b1;
    #1;
  endtask

  // ----
  // character clock
  // ----
  // one pulse per cell; each level held at least 2 mclk so the synchroniser sees it
  task automatic tick();
    @(posedge mclk);
    char_clock_in <= 1'b1;
    repeat (2) @(posedge mclk);
    char_clock_in <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
  endtask
endmodule

// ==== tb/cvt_video_timing_tb.sv ====
// self-checking bench: register port and raster timing against a behavioural model
`include "cvt_regs.svh"

module cvt_video_timing_tb;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int HT = 23;
  localparam int CPR = 20;
  localparam int LINES = 256;
  localparam int VDS = 5;

  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic chipEnable_n, hostRead, host_strobe, char_clock_in, busOe, hs, vs, cs, bl, cur;
  logic [3:0] reg_select_lines, scanOut;
  logic [7:0] hostData, busOut, colOut, got;
  logic [5:0] rowOut;
  int bad_count = 0;
  int check_count = 0;
  int c, v, curCol, curRow;
  int fld = 0;
  logic ilace = 1'b0;

  always #20 mclk = ~mclk;

  cvt_video_timing cvt_video_timing_i (
    .mclk(mclk), .reset_n(reset_n), .char_clock_in(char_clock_in),
    .chipEnable_n(chipEnable_n), .hostRead(hostRead), .host_strobe(host_strobe),
    .reg_select_lines(reg_select_lines), .host_data_bus_in(busOe ? busOut : hostData),
    .host_data_bus_out(busOut), .host_data_bus_oe(busOe),
    .column_count_out(colOut), .row_count_out(rowOut), .raster_line_count(scanOut),
    .hsyncOut(hs), .vsyncOut(vs), .csyncOut(cs), .blankOut(bl), .cursorOut(cur)
  );

  cvt_host_model host_i (
    .mclk(mclk), .chipEnable_n(chipEnable_n), .hostRead(hostRead), .host_strobe(host_strobe),
    .reg_select_lines(reg_select_lines), .hostData(hostData), .host_data_bus_oe(busOe),
    .host_data_bus_out(busOut), .char_clock_in(char_clock_in)
  );

  // ----
  // checking
  // ----
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] sel, input logic [7:0] d);
    host_i.access(sel, d, 1'b0, 1'b1, got);
  endtask

  // model position c, v: two rows of two scans from line VDS, scroll 0
  task automatic check_video();
    int k;
    logic disp, h, vsx;
    k = v - VDS;
    disp = (k >= 0) && (k < 4);
    h = (c >= CPR + 1) && (c <= CPR + 2);
    // odd interlaced field: vsync starts and ends half a line late
    if (ilace && fld == 1) begin
      vsx = (v == 0 && c >= HT / 2) || (v > 0 && v < `CVT_VSYNC_LINES) || (v == `CVT_VSYNC_LINES && c < HT / 2);
    end else begin
      vsx = v < `CVT_VSYNC_LINES;
    end
    chk(colOut, 8'(c));
    chk(hs, h);
    chk(vs, vsx);
    chk(cs, vsx ? !h : h);
    chk(bl, !(disp && c < CPR));
    chk(cur, disp && c < CPR && c == curCol && ((k / 2 + 1) % 2) == curRow);
    if (disp) begin
      chk(scanOut, 8'(k % 2));
      chk(rowOut, 8'((k / 2 + 1) % 2));
    end
  endtask

  // one cell of the model: column, line and, when interlaced, field wrap
  task automatic step();
    host_i.tick();
    if (c == HT) begin
      c = 0;
      if (v == LINES - 1 + ((ilace && fld == 1) ? 1 : 0)) begin
        v = 0;
        fld = ilace ? 1 - fld : 0;
      end else begin
        v++;
      end
    end else begin
      c++;
    end
    check_video();
  endtask

  // ----
  // tests
  // ----
  initial begin
    void'($urandom(32'h8127));
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    for (int a = 0; a <= 8; a++) begin
      host_i.access(4'(a), 8'h00, 1'b1, 1'b1, got);
      chk(got, 8'h00);
    end
    curCol = $urandom_range(CPR - 1, 0);
    curRow = $urandom_range(1, 0);
    wr(`CVT_REG_CURSOR_COL, 8'(curCol));
    wr(`CVT_REG_CURSOR_ROW, 8'(curRow));
    // chip enable left off: the write must not land
    host_i.access(`CVT_REG_CURSOR_COL, ~8'(curCol), 1'b0, 1'b0, got);
    host_i.access(`CVT_REG_CURSOR_COL, 8'h00, 1'b1, 1'b1, got);
    chk(got, 8'(curCol));
    host_i.access(`CVT_REG_CURSOR_ROW, 8'h00, 1'b1, 1'b1, got);
    chk(got, 8'(curRow));
    wr(`CVT_REG_HTOTAL, 8'(HT));
    wr(`CVT_REG_SYNC_CONFIG, 8'h11);
    wr(`CVT_REG_ROW_FORMAT, 8'h88);
    wr(`CVT_REG_SKEW_ROWS, 8'h01);
    // four display lines stay well inside the frame
    wr(`CVT_REG_FRAME_LINES, 8'h00);
    wr(`CVT_REG_VDATA_START, 8'(VDS));
    wr(`CVT_REG_SCROLL, 8'hC0);
    wr(`CVT_REG_RESTART, 8'h00);
    c = 0;
    v = 0;
    check_video();
    for (int n = 0; n < (LINES + 2) * (HT + 1); n++) begin
      step();
    end
    // sync skew of one character time
    wr(`CVT_REG_SKEW_ROWS, 8'h81);
    wr(`CVT_REG_RESTART, 8'h00);
    for (int n = 1; n <= HT; n++) begin
      host_i.tick();
      chk(hs, n >= CPR + 2 && n <= CPR + 3);
    end
    // interlaced: even field of 256 lines, then into the 257-line odd field
    wr(`CVT_REG_SKEW_ROWS, 8'h01);
    wr(`CVT_REG_SYNC_CONFIG, 8'h91);
    wr(`CVT_REG_RESTART, 8'h00);
    c = 0;
    v = 0;
    fld = 0;
    ilace = 1'b1;
    check_video();
    for (int n = 0; n < (LINES + 4) * (HT + 1); n++) begin
      step();
    end
    summarize();
  end

  // a hang ends the run as a mismatch
  initial begin
    #3_200_000;
    bad_count++;
    summarize();
  end
endmodule
